// ### core/iocc_pkg.sv
// package for the i/o instruction condition code resolver
package iocc_pkg;

	// ----------------------------------------
	// instruction codes
	// ----------------------------------------
	localparam logic [2:0] IOCC_OP_START = 3'h0;
	localparam logic [2:0] IOCC_OP_TEST = 3'h1;
	localparam logic [2:0] IOCC_OP_HALT = 3'h2;
	localparam logic [2:0] IOCC_OP_FLAG = 3'h3;
	localparam logic [2:0] IOCC_OP_TCHAN = 3'h4;

	// ----------------------------------------
	// component states
	// ----------------------------------------
	localparam logic [1:0] IOCC_ST_AVAIL = 2'h0;
	localparam logic [1:0] IOCC_ST_INTR = 2'h1;
	localparam logic [1:0] IOCC_ST_WORK = 2'h2;
	localparam logic [1:0] IOCC_ST_INOP = 2'h3;

	// ----------------------------------------
	// condition codes and status word layout
	// ----------------------------------------
	localparam logic [1:0] IOCC_CC0 = 2'h0;
	localparam logic [1:0] IOCC_CC1 = 2'h1;
	localparam logic [1:0] IOCC_CC2 = 2'h2;
	localparam logic [1:0] IOCC_CC3 = 2'h3;
	localparam int IOCC_PSW_CC_HI = 34;
	localparam int IOCC_PSW_CC_LO = 35;
	localparam logic [7:0] IOCC_STATUS_ADDR = 8'h40;
	localparam int IOCC_ADDR_ZERO_HI = 16;
	localparam int IOCC_ADDR_ZERO_LO = 19;

	// ----------------------------------------
	// register map (byte addresses)
	// ----------------------------------------
	localparam logic [7:0] IOCC_REG_CTRL = 8'h00;
	localparam logic [7:0] IOCC_REG_STATE = 8'h04;
	localparam logic [7:0] IOCC_REG_ERR = 8'h08;
	localparam logic [7:0] IOCC_REG_RESULT = 8'h0c;
	localparam logic [7:0] IOCC_REG_PSW = 8'h10;
	localparam logic [7:0] IOCC_REG_CSR = 8'h14;
	localparam logic [31:0] IOCC_RST_WORD = 32'h0000_0000;

	// ----------------------------------------
	// error bit positions in the error register
	// ----------------------------------------
	localparam int IOCC_E_ADDR_PAR = 0;
	localparam int IOCC_E_ADDR_MIS = 1;
	localparam int IOCC_E_STAT_PAR = 2;
	localparam int IOCC_E_TIMING = 3;
	localparam int IOCC_E_CTRL = 4;
	localparam int IOCC_E_PROG0 = 8;
	localparam int IOCC_E_NPROG = 8;
	localparam int IOCC_ERR_W = 16;

	// status bits stored into the channel status record
	localparam int IOCC_S_CHAN_CTRL = 0;
	localparam int IOCC_S_IFACE_CTRL = 1;
	localparam int IOCC_S_PROG = 2;
	localparam int IOCC_S_DEV = 3;

	typedef enum logic [2:0] {
		IOCC_IDLE = 3'b001,
		IOCC_EVAL = 3'b010,
		IOCC_DONE = 3'b100
	} iocc_state_e;

endpackage : iocc_pkg

// ### core/iocc_core.sv
// condition code resolver for the five i/o instructions, with wishbone slave
`timescale 1ns/100ps
// ----------------------------------------
// Behaviour
// - outcome is a two-bit code placed at status word bits 34 and 35
// - code updates when the instruction finishes and the processor may proceed
// - all available: start 0/1 by op type, test/flag/tchan 0, halt 1 stored
// - device pending or working: start/test/halt 1 stored; inoperative 3; flag/tchan 0
// - subchannel pending/working codes per instruction, test same device 1 stored
// - channel pending: test channel 1, others treat channel as available
// - stored outcomes write the status record to location 64
// - other than on test channel, available outcome only when no error was detected
// - programming error with channel or subchannel working returns 2
// - programming error with inoperative part returns 3
// - test of same device on pending subchannel with inoperative device returns 3
// - halt on working multiplex subchannel with inoperative device returns 3
// - channel equipment error gives 1 stored except on test channel; start programming error gives 1
// - returned device address parity or mismatch is an equipment error
// - unit status byte parity failure is an equipment error
// - mistimed or wrong-length device signal is an equipment error
// - fault in own control equipment is a channel equipment error
// - may malfunction reset; stored status shows control or interface check
// - start detects address pointer and first command entry errors
// - nonzero address bits 16 to 19 give 3 without channel selection
module iocc_core
	import iocc_pkg::*;
(
	// clock and reset
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic clk_en,
	// wishbone slave
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	// status storage and reset outputs
	output logic status_store,
	output logic [7:0] status_store_addr,
	output logic [15:0] status_store_data,
	output logic malfunction_reset,
	output logic instr_done
);

	// ----------------------------------------
	// reset release
	// ----------------------------------------
	logic rst_s1_reg;
	logic rst_s2_reg;
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			rst_s1_reg <= 1'b0;
			rst_s2_reg <= 1'b0;
		end else begin
			rst_s1_reg <= 1'b1;
			rst_s2_reg <= rst_s1_reg;
		end
	end
	logic rstn;
	assign rstn = rst_s2_reg;

	// ----------------------------------------
	// registers
	// ----------------------------------------
	// ctrl: [2:0] op, [3] go, [4] start immediate op, [5] same device, [6] multiplex
	// state: [1:0] channel, [3:2] subchannel, [5:4] device, [31:16] address sum
	logic [31:0] ctrl_reg;
	logic [31:0] state_reg;
	logic [IOCC_ERR_W-1:0] err_reg;
	logic [63:0] psw_reg;
	logic [15:0] csr_reg;
	logic [1:0] cc_reg;
	logic stored_reg;
	logic sel_skip_reg;
	logic wb_ack_reg;
	logic [31:0] rdata_reg;
	iocc_state_e st_reg;
	logic go;

	logic acc;
	logic [31:0] err_wr;
	assign acc = wb_cyc_i && wb_stb_i && !wb_ack_reg;
	assign go = acc && wb_we_i && wb_adr_i == IOCC_REG_CTRL && wb_sel_i[0] && wb_dat_i[3];

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
		input logic [3:0] sel);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (sel[i]) begin
				r[i*8 +: 8] = d[i*8 +: 8];
			end
		end
		return r;
	endfunction : merge

	// error register is narrower than the bus word: merge at full width, then cut
	assign err_wr = merge({16'h0000, err_reg}, wb_dat_i, wb_sel_i);

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			ctrl_reg <= IOCC_RST_WORD;
			state_reg <= IOCC_RST_WORD;
			err_reg <= '0;
		end else if (clk_en && acc && wb_we_i) begin
			unique case (wb_adr_i)
				IOCC_REG_CTRL: ctrl_reg <= merge(ctrl_reg, wb_dat_i, wb_sel_i) & 32'h0000_0077;
				IOCC_REG_STATE: state_reg <= merge(state_reg, wb_dat_i, wb_sel_i);
				IOCC_REG_ERR: err_reg <= err_wr[IOCC_ERR_W-1:0];
				default: ;
			endcase
		end
	end

	// ----------------------------------------
	// bus answer: one-cycle ack, unmapped reads zero
	// ----------------------------------------
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			wb_ack_reg <= 1'b0;
			rdata_reg <= IOCC_RST_WORD;
		end else if (clk_en) begin
			wb_ack_reg <= acc;
			if (acc && !wb_we_i) begin
				unique case (wb_adr_i)
					IOCC_REG_CTRL: rdata_reg <= ctrl_reg;
					IOCC_REG_STATE: rdata_reg <= state_reg;
					IOCC_REG_ERR: rdata_reg <= {16'h0000, err_reg};
					IOCC_REG_RESULT: rdata_reg <= {24'h000000, st_reg == IOCC_IDLE,
						sel_skip_reg, stored_reg, 3'h0, cc_reg};
					// status word bits 32..63 live in the low half, bit 0 being the msb
					IOCC_REG_PSW: rdata_reg <= psw_reg[31:0];
					IOCC_REG_CSR: rdata_reg <= {16'h0000, csr_reg};
					default: rdata_reg <= IOCC_RST_WORD;
				endcase
			end
		end
	end
	assign wb_ack_o = wb_ack_reg;
	assign wb_dat_o = rdata_reg;

	// ----------------------------------------
	// condition code resolution
	// ----------------------------------------
	logic [2:0] op;
	logic [1:0] ch, sc, dv;
	logic equip_err, prog_err, addr_bad;
	logic [1:0] cc_next;
	logic store_next;
	assign op = ctrl_reg[2:0];
	assign ch = state_reg[1:0];
	assign sc = state_reg[3:2];
	assign dv = state_reg[5:4];
	assign addr_bad = state_reg[IOCC_ADDR_ZERO_LO:IOCC_ADDR_ZERO_HI] != 4'h0;
	assign equip_err = |err_reg[IOCC_E_CTRL:IOCC_E_ADDR_PAR];
	assign prog_err = (op == IOCC_OP_START) && |err_reg[IOCC_E_PROG0 +: IOCC_E_NPROG];

	always_comb begin
		cc_next = IOCC_CC0;
		store_next = 1'b0;
		if (addr_bad || ch == IOCC_ST_INOP) begin
			cc_next = IOCC_CC3;
		end else if (op == IOCC_OP_TCHAN) begin
			if (ch == IOCC_ST_INTR) cc_next = IOCC_CC1;
			else if (ch == IOCC_ST_WORK) cc_next = IOCC_CC2;
		end else if (ch == IOCC_ST_WORK) begin
			cc_next = IOCC_CC2;
		end else if (prog_err && (sc == IOCC_ST_WORK)) begin
			cc_next = IOCC_CC2;
		end else if (prog_err && (sc == IOCC_ST_INOP || dv == IOCC_ST_INOP)) begin
			cc_next = IOCC_CC3;
		end else if (equip_err && op != IOCC_OP_TCHAN) begin
			cc_next = IOCC_CC1;
			store_next = 1'b1;
		end else if (prog_err) begin
			cc_next = IOCC_CC1;
			store_next = 1'b1;
		end else begin
			// channel pending is treated as available here
			unique case (sc)
				IOCC_ST_INTR: begin
					if (op == IOCC_OP_HALT) cc_next = IOCC_CC0;
					else if (op == IOCC_OP_TEST && ctrl_reg[5]) begin
						if (dv == IOCC_ST_INOP) cc_next = IOCC_CC3;
						else begin
							cc_next = IOCC_CC1;
							store_next = 1'b1;
						end
					end else cc_next = IOCC_CC2;
				end
				IOCC_ST_WORK: begin
					if (op == IOCC_OP_HALT) begin
						if (ctrl_reg[6] && dv == IOCC_ST_INOP) cc_next = IOCC_CC3;
						else begin
							cc_next = IOCC_CC1;
							store_next = 1'b1;
						end
					end else cc_next = IOCC_CC2;
				end
				IOCC_ST_INOP: cc_next = (op == IOCC_OP_HALT) ? IOCC_CC0 : IOCC_CC3;
				IOCC_ST_AVAIL: begin
					if (op == IOCC_OP_FLAG) cc_next = IOCC_CC0;
					else unique case (dv)
						IOCC_ST_INOP: cc_next = IOCC_CC3;
						IOCC_ST_INTR, IOCC_ST_WORK: begin
							cc_next = IOCC_CC1;
							store_next = 1'b1;
						end
						IOCC_ST_AVAIL: begin
							if (op == IOCC_OP_HALT || (op == IOCC_OP_START && ctrl_reg[4])) begin
								cc_next = IOCC_CC1;
								store_next = 1'b1;
							end
						end
					endcase
				end
			endcase
		end
	end

	// ----------------------------------------
	// instruction sequencing
	// ----------------------------------------
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			st_reg <= IOCC_IDLE;
			cc_reg <= IOCC_CC0;
			stored_reg <= 1'b0;
			sel_skip_reg <= 1'b0;
			psw_reg <= '0;
			csr_reg <= '0;
			status_store <= 1'b0;
			status_store_addr <= 8'h00;
			status_store_data <= 16'h0000;
			malfunction_reset <= 1'b0;
			instr_done <= 1'b0;
		end else if (clk_en) begin
			status_store <= 1'b0;
			malfunction_reset <= 1'b0;
			instr_done <= 1'b0;
			unique case (st_reg)
				IOCC_IDLE: if (go) st_reg <= IOCC_EVAL;
				IOCC_EVAL: begin
					// status written while executing, before completion
					cc_reg <= cc_next;
					stored_reg <= store_next;
					sel_skip_reg <= addr_bad;
					if (store_next) begin
						status_store <= 1'b1;
						status_store_addr <= IOCC_STATUS_ADDR;
						status_store_data <= {12'h000, 1'b0, prog_err,
							equip_err && (|err_reg[IOCC_E_TIMING:IOCC_E_ADDR_PAR]),
							equip_err && err_reg[IOCC_E_CTRL]};
						csr_reg <= {12'h000, 1'b0, prog_err,
							equip_err && (|err_reg[IOCC_E_TIMING:IOCC_E_ADDR_PAR]),
							equip_err && err_reg[IOCC_E_CTRL]};
					end
					// control equipment faults reset the channel unless address bits 16 to 19 are nonzero
					malfunction_reset <= equip_err && err_reg[IOCC_E_CTRL] && !addr_bad;
					st_reg <= IOCC_DONE;
				end
				IOCC_DONE: begin
					psw_reg[63-IOCC_PSW_CC_HI] <= cc_reg[1];
					psw_reg[63-IOCC_PSW_CC_LO] <= cc_reg[0];
					instr_done <= 1'b1;
					st_reg <= IOCC_IDLE;
				end
				default: st_reg <= IOCC_IDLE;
			endcase
		end
	end

endmodule : iocc_core

// ### sim/iocc_core_sva.sv
// port assertions for the i/o condition code resolver
`timescale 1ns/100ps
module iocc_core_sva
	import iocc_pkg::*;
(
	// clock and reset
	input wire logic mclk,
	input wire logic rst_n,
	// wishbone
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [31:0] wb_dat_i,
	input wire logic wb_ack_o,
	// results
	input wire logic status_store,
	input wire logic [7:0] status_store_addr,
	input wire logic [15:0] status_store_data,
	input wire logic malfunction_reset,
	input wire logic instr_done
);
	logic go;
	logic [3:0] since_reg;
	assign go = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o && wb_adr_i == IOCC_REG_CTRL
		&& wb_dat_i[3];
	// saturating, so a stray pulse long after any start still fails
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n)
			since_reg <= 4'hf;
		else if (go)
			since_reg <= 4'h0;
		else if (since_reg != 4'hf)
			since_reg <= since_reg + 4'h1;
	end
	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_n);
	a_ack_one_cycle: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
	a_ack_next_edge: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
		else $error("ack late");
	a_ack_has_req: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
		else $error("ack without request");
	a_store_addr: assert property (status_store |-> status_store_addr == IOCC_STATUS_ADDR)
		else $error("store address wrong");
	a_store_in_exec: assert property (status_store |-> since_reg inside {[1:4]})
		else $error("store outside instruction");
	a_done_after_go: assert property (instr_done |-> since_reg inside {[2:5]})
		else $error("done at wrong time");
	a_done_single: assert property (instr_done |=> !instr_done)
		else $error("done too long");
	a_malf_near_store: assert property (status_store && status_store_data[IOCC_S_CHAN_CTRL]
		|-> (malfunction_reset || $past(malfunction_reset)) or (##[1:2] malfunction_reset))
		else $error("no malfunction reset");
endmodule : iocc_core_sva
bind iocc_core iocc_core_sva chk_u (.mclk(mclk), .rst_n(rst_n), .wb_cyc_i(wb_cyc_i),
	.wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i),
	.wb_ack_o(wb_ack_o), .status_store(status_store), .status_store_addr(status_store_addr),
	.status_store_data(status_store_data), .malfunction_reset(malfunction_reset),
	.instr_done(instr_done));

// ### sim/iocc_store_mdl.sv
// storage model that receives the status record
`timescale 1ns/100ps
module iocc_store_mdl
	import iocc_pkg::*;
(
	// clock and reset
	input wire logic mclk,
	input wire logic rst_n,
	// store request
	input wire logic store,
	input wire logic [7:0] store_addr,
	input wire logic [15:0] store_data,
	// contents seen
	output logic [15:0] rec_reg,
	output logic [7:0] cnt_reg
);
	// only location 64 exists here, so a misaimed record goes missing
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			rec_reg <= 16'h0;
			cnt_reg <= 8'h0;
		end else if (store && store_addr == IOCC_STATUS_ADDR) begin
			rec_reg <= store_data;
			cnt_reg <= cnt_reg + 8'h1;
		end
	end
endmodule : iocc_store_mdl

// ### sim/tb_top.sv
// self-checking bench for the i/o condition code resolver
`timescale 1ns/100ps
module tb_top import iocc_pkg::*;;
	logic mclk, rst_n, req, we, ack, st, malf, done;
	logic [7:0] adr, cnt;
	logic [31:0] dat, q_o;
	logic [7:0] st_a;
	logic [15:0] st_d, rec;
	int err_count = 0;
	int check_count = 0;
	iocc_core dut_u (.mclk(mclk), .rst_n(rst_n), .clk_en(1'b1), .wb_cyc_i(req), .wb_stb_i(req),
		.wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(dat), .wb_dat_o(q_o),
		.wb_ack_o(ack), .status_store(st), .status_store_addr(st_a), .status_store_data(st_d),
		.malfunction_reset(malf), .instr_done(done));
	iocc_store_mdl mdl_u (.mclk(mclk), .rst_n(rst_n), .store(st), .store_addr(st_a),
		.store_data(st_d), .rec_reg(rec), .cnt_reg(cnt));
	initial mclk = 1'b0;
	always #25 mclk = ~mclk;
	task automatic wrap_up();
		$display("checks %0d errors %0d", check_count, err_count);
		if (err_count == 0 && check_count > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : wrap_up
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			err_count++;
			$display("Error %0t: got %h want %h", $time, seen, exp);
		end
	endtask : chk
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] q);
		int n;
		n = 0;
		@(posedge mclk);
		req <= 1'b1;
		we <= w;
		adr <= a;
		dat <= d;
		do begin
			@(posedge mclk);
			n++;
		end while (ack !== 1'b1 && n < 20);
		q = q_o;
		req <= 1'b0;
		if (n >= 20) begin
			err_count++;
			wrap_up();
		end
	endtask : xfer
	// result layout: valid, skipped, stored, code; valid low marks a case left open
	function automatic logic [4:0] exp_cc(input logic [6:0] c, input logic [31:0] s,
		input logic [15:0] er);
		logic [2:0] op;
		logic [1:0] ch, sc, dv;
		op = c[2:0];
		ch = s[1:0];
		sc = s[3:2];
		dv = s[5:4];
		if (s[19:16] != 4'h0) return 5'h1b;
		if (ch == IOCC_ST_INOP) return 5'h13;
		if (op == IOCC_OP_TCHAN) return (ch == IOCC_ST_WORK) ? 5'h12 : {4'h8, ch == IOCC_ST_INTR};
		if (ch == IOCC_ST_WORK) return (op == IOCC_OP_TEST) ? 5'h00 : 5'h12;
		if (er[15:8] != 8'h0) begin
			if (op != IOCC_OP_START) return 5'h00;
			if (sc == IOCC_ST_WORK) return 5'h12;
			if (sc == IOCC_ST_INOP || dv == IOCC_ST_INOP) return 5'h13;
			return (s[5:2] == 4'h0) ? 5'h15 : 5'h00;
		end
		if (er[4:0] != 5'h0) return (s[5:2] == 4'h0) ? 5'h15 : 5'h00;
		if (sc == IOCC_ST_INTR) begin
			if (op == IOCC_OP_HALT) return 5'h10;
			if (op != IOCC_OP_TEST) return 5'h12;
			if (dv == IOCC_ST_INOP) return c[5] ? 5'h13 : 5'h00;
			return c[5] ? 5'h15 : 5'h12;
		end
		if (sc == IOCC_ST_WORK) begin
			if (op != IOCC_OP_HALT) return 5'h12;
			return (c[6] && dv == IOCC_ST_INOP) ? 5'h13 : 5'h15;
		end
		if (sc == IOCC_ST_INOP) return (op == IOCC_OP_START || op == IOCC_OP_HALT) ? 5'h00 : 5'h13;
		if (op == IOCC_OP_FLAG) return 5'h10;
		if (dv == IOCC_ST_INOP) return 5'h13;
		if (dv != IOCC_ST_AVAIL) return 5'h15;
		if (op == IOCC_OP_START) return c[4] ? 5'h15 : 5'h10;
		return (op == IOCC_OP_HALT) ? 5'h15 : 5'h10;
	endfunction : exp_cc
	task automatic run_op(input logic [6:0] c, input logic [31:0] s, input logic [15:0] er);
		logic [31:0] q;
		logic [4:0] e;
		logic [7:0] n0;
		int n;
		e = exp_cc(c, s, er);
		xfer(1'b1, IOCC_REG_STATE, s, q);
		xfer(1'b1, IOCC_REG_ERR, 32'(er), q);
		n0 = cnt;
		xfer(1'b1, IOCC_REG_CTRL, 32'({c[6:4], 1'b1, c[2:0]}), q);
		n = 0;
		do begin
			xfer(1'b0, IOCC_REG_RESULT, 32'h0, q);
			n++;
		end while (q[7] !== 1'b1 && n < 10);
		if (n >= 10) begin
			err_count++;
			wrap_up();
		end
		chk(32'(q[1:0]), 32'(e[1:0]));
		chk(32'(q[6:5]), 32'(e[3:2]));
		chk(32'(cnt - n0), 32'(e[2]));
		if (er != 16'h0 && e[2]) chk(32'(rec[2:0]), 32'({|er[15:8], |er[3:0], er[4]}));
		xfer(1'b0, IOCC_REG_PSW, 32'h0, q);
		chk(32'(q[29:28]), 32'(e[1:0]));
	endtask : run_op
	initial begin
		logic [31:0] s;
		logic [6:0] c;
		int i;
		rst_n = 1'b0;
		req = 1'b0;
		we = 1'b0;
		adr = 8'h0;
		dat = 32'h0;
		s = $urandom(32'hbde9e545);
		repeat (5) @(posedge mclk);
		rst_n <= 1'b1;
		repeat (2) @(posedge mclk);
		for (i = 0; i < 5; i++) run_op(7'(i), 32'h0, 16'h0);
		for (i = 0; i < 5; i++) run_op(7'(i % 4), 32'h0, 16'(1 << i));
		run_op(7'h10, 32'h0, 16'h0);
		run_op(7'h00, 32'h0001_0000, 16'h0);
		run_op(7'h04, 32'h0008_0000, 16'h0);
		run_op(7'h04, 32'h1, 16'h0);
		run_op(7'h00, 32'h1, 16'h0);
		run_op(7'h00, 32'h0, 16'h0100);
		run_op(7'h00, 32'h8, 16'h0200);
		run_op(7'h00, 32'h30, 16'h8000);
		run_op(7'h21, 32'h34, 16'h0);
		run_op(7'h42, 32'h38, 16'h0);
		for (i = 0; i < 150; i++) begin
			do begin
				c = {3'($urandom_range(0, 7)), 1'b0, 3'($urandom_range(0, 4))};
				s = {12'h0, ($urandom_range(0, 15) == 0) ? 4'($urandom) : 4'h0, 10'h0, 6'($urandom)};
			end while (exp_cc(c, s, 16'h0) < 5'h10);
			run_op(c, s, 16'h0);
		end
		wrap_up();
	end
endmodule : tb_top
